// File: absenc_pkg.sv
package absenc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_ENC_TYPE  = 8'h00;
  localparam logic [7:0] ADDR_MODE      = 8'h04;
  localparam logic [7:0] ADDR_OFS_LOW   = 8'h08;
  localparam logic [7:0] ADDR_OFS_HIGH  = 8'h0c;
  localparam logic [7:0] ADDR_SHIELD    = 8'h10;
  localparam logic [7:0] ADDR_MECH_POS  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] ADDR_CONTROL   = 8'h20;
  localparam logic [7:0] ADDR_STATUS    = 8'h24;
  localparam logic [7:0] ADDR_TARGET    = 8'h28;
  localparam logic [7:0] ADDR_POS_ERROR = 8'h2c;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_HOME_BIT   = 0;
  localparam int CTRL_FRESET_BIT = 1;
  localparam int EV_OVERFLOW     = 0;
  localparam int EV_BATT_FAIL    = 1;
  localparam int EV_BATT_LOW     = 2;
  localparam int EV_STO_TRIP     = 3;
  localparam int NUM_EVENTS      = 4;
  localparam int NUM_FAULTS      = 3;
  localparam int SHIELD_LOW_BIT  = 0;
  localparam int SHIELD_FAIL_BIT = 1;
  localparam int STAT_STO_A_BIT  = 3;
  localparam int STAT_STO_B_BIT  = 4;
  localparam int STAT_TORQUE_BIT = 5;
  localparam int STAT_RES24_BIT  = 6;

  // ----------------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------------
  localparam int              TURN_BITS       = 16;
  localparam int              RES_LOW_BITS    = 17;
  localparam int              RES_HIGH_BITS   = 24;
  localparam logic [15:0]     ENC_TYPE_24BIT  = 16'h0002;
  localparam logic [15:0]     ENC_TYPE_RESET  = 16'h0000;
  localparam logic            MODE_ABSOLUTE   = 1'b1;
  localparam logic            MODE_RESET      = 1'b0;
  localparam logic [15:0]     TURN_FWD_LIMIT  = 16'h7fff;
  localparam logic [15:0]     TURN_REV_WRAP   = 16'h8000;
  localparam logic [1:0]      RESP_OKAY       = 2'b00;
  localparam logic [1:0]      RESP_SLVERR     = 2'b10;

endpackage

// File: absolute_encoder_position_tracker.sv
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module absolute_encoder_position_tracker
  import absenc_pkg::*;
#(
  parameter logic [1:0] BATT_SHIELD = 2'b00  // Value of battery_alarm_mask.
) (
  input  wire logic        core_clk,        // System clock, 20 MHz.
  input  wire logic        sys_rst,         // Asynchronous reset, active high.
  input  wire logic [7:0]  s_axi_awaddr,    // Write address.
  input  wire logic        s_axi_awvalid,   // Write address valid.
  output logic             s_axi_awready,   // Write address ready.
  input  wire logic [31:0] s_axi_wdata,     // Write data.
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes.
  input  wire logic        s_axi_wvalid,    // Write data valid.
  output logic             s_axi_wready,    // Write data ready.
  output logic [1:0]       s_axi_bresp,     // Write response.
  output logic             s_axi_bvalid,    // Write response valid.
  input  wire logic        s_axi_bready,    // Write response ready.
  input  wire logic [7:0]  s_axi_araddr,    // Read address.
  input  wire logic        s_axi_arvalid,   // Read address valid.
  output logic             s_axi_arready,   // Read address ready.
  output logic [31:0]      s_axi_rdata,     // Read data.
  output logic [1:0]       s_axi_rresp,     // Read response.
  output logic             s_axi_rvalid,    // Read data valid.
  input  wire logic        s_axi_rready,    // Read data ready.
  input  wire logic        enc_valid,       // Encoder sample strobe.
  input  wire logic [15:0] enc_turns,       // Signed multi-turn count.
  input  wire logic [23:0] enc_single,      // Single-turn position.
  input  wire logic        enc_batt_first,  // Battery first powered flag.
  input  wire logic        enc_batt_low,    // Battery voltage low flag.
  input  wire logic        sto_chan_a,      // Safe torque off channel a pin.
  input  wire logic        sto_chan_b,      // Safe torque off channel b pin.
  output logic             torque_enable,   // Torque output allowed.
  output logic [31:0]      mech_position,   // Mechanical position.
  output logic [2:0]       fault_flags,     // Latched encoder faults.
  output logic             irq              // Interrupt, level.
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]            sync_a;
    logic [2:0]            sync_b;
    logic                  sto_a;
    logic                  sto_b;
    logic                  torque;
    logic [15:0]           enc_type;
    logic                  abs_mode;
    logic [63:0]           offset;
    logic [63:0]           home_base;
    logic [63:0]           raw_pos;
    logic [15:0]           prev_turns;
    logic                  have_sample;
    logic [31:0]           mech;
    logic [31:0]           target;
    logic [NUM_FAULTS-1:0] fault;
    logic [NUM_EVENTS-1:0] irq_stat;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } state_type;

  state_type s;
  state_type n;

  logic                  aw_fire;
  logic                  ar_fire;
  logic                  home_cmd;
  logic                  freset_cmd;
  logic                  wrap;
  logic [63:0]           sample_pos;
  logic [63:0]           enc_pos;
  logic [NUM_EVENTS-1:0] ev;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [63:0] compose(input logic [15:0] turns,
                                          input logic [23:0] single,
                                          input logic        res24);
    logic [63:0] t;
    t = {{48{turns[15]}}, turns};
    if (res24) begin
      compose = (t << RES_HIGH_BITS) | {40'h0, single};
    end else begin
      compose = (t << RES_LOW_BITS) | {47'h0, single[16:0]};
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'b00) && (addr <= ADDR_POS_ERROR);
  endfunction

  // ----------------------------------------------------------------------
  // Handshakes and outputs
  // ----------------------------------------------------------------------
  // Address and data are taken together so a write never sits half-accepted.
  assign aw_fire       = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
  assign ar_fire       = s_axi_arvalid && !s.rvalid;
  assign s_axi_awready = aw_fire;
  assign s_axi_wready  = aw_fire;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;
  assign torque_enable = s.torque;
  assign mech_position = s.mech;
  assign fault_flags   = s.fault;
  assign irq           = |(s.irq_stat & s.irq_mask);

  assign home_cmd   = aw_fire && s_axi_awaddr == ADDR_CONTROL && s_axi_wstrb[0]
                      && s_axi_wdata[CTRL_HOME_BIT];
  assign freset_cmd = aw_fire && s_axi_awaddr == ADDR_CONTROL && s_axi_wstrb[0]
                      && s_axi_wdata[CTRL_FRESET_BIT];
  assign sample_pos = compose(enc_turns, enc_single, s.enc_type == ENC_TYPE_24BIT);
  // A jump across the sign boundary between the two outer quarters is a wrap.
  assign wrap = (s.prev_turns[15:14] == 2'b01 && enc_turns[15:14] == 2'b10)
             || (s.prev_turns[15:14] == 2'b10 && enc_turns[15:14] == 2'b01);
  // Absolute mode uses the battery-backed count as is; incremental is relative.
  assign enc_pos = s.abs_mode ? s.raw_pos : s.raw_pos - s.home_base;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n  = s;
    ev = '0;

    // The first stage feeds only the second; a level counts once 2 and 3 agree.
    n.sync_a = {s.sync_a[1:0], sto_chan_a};
    n.sync_b = {s.sync_b[1:0], sto_chan_b};
    if (s.sync_a[2] == s.sync_a[1]) begin
      n.sto_a = s.sync_a[2];
    end
    if (s.sync_b[2] == s.sync_b[1]) begin
      n.sto_b = s.sync_b[2];
    end
    n.torque = n.sto_a && n.sto_b;
    ev[EV_STO_TRIP] = s.torque && !n.torque;

    if (enc_valid) begin
      n.raw_pos     = sample_pos;
      n.prev_turns  = enc_turns;
      n.have_sample = 1'b1;
      if (!s.have_sample && !s.abs_mode) begin
        n.home_base = sample_pos;
      end
      if (s.abs_mode && s.have_sample && wrap) begin
        ev[EV_OVERFLOW] = 1'b1;
      end
      if (s.abs_mode && enc_batt_first && !BATT_SHIELD[SHIELD_FAIL_BIT]) begin
        ev[EV_BATT_FAIL] = 1'b1;
        n.offset         = sample_pos;
      end
      if (enc_batt_low && !BATT_SHIELD[SHIELD_LOW_BIT]) begin
        ev[EV_BATT_LOW] = 1'b1;
      end
    end

    if (home_cmd) begin
      if (s.abs_mode) begin
        n.offset = s.raw_pos;
      end else begin
        n.home_base = s.raw_pos;
        n.offset    = '0;
      end
    end

    n.mech = enc_pos[31:0] - s.offset[31:0];

    // A new fault beats a reset arriving in the same cycle.
    n.fault = (freset_cmd ? '0 : s.fault) | ev[NUM_FAULTS-1:0];

    if (aw_fire && s_axi_awaddr == ADDR_IRQ_STAT && s_axi_wstrb[0]) begin
      n.irq_stat = s.irq_stat & ~s_axi_wdata[NUM_EVENTS-1:0];
    end
    n.irq_stat = n.irq_stat | ev;

    if (aw_fire) begin
      unique case (s_axi_awaddr)
        ADDR_ENC_TYPE: n.enc_type = 16'(merge({16'h0, s.enc_type}, s_axi_wdata, s_axi_wstrb));
        ADDR_MODE: begin
          if (s_axi_wstrb[0]) begin
            n.abs_mode = s_axi_wdata[0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (s_axi_wstrb[0]) begin
            n.irq_mask = s_axi_wdata[NUM_EVENTS-1:0];
          end
        end
        ADDR_TARGET: n.target = merge(s.target, s_axi_wdata, s_axi_wstrb);
        default: begin
        end
      endcase
      n.bvalid = 1'b1;
      n.bresp  = mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    if (ar_fire) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        ADDR_ENC_TYPE:  n.rdata = {16'h0, s.enc_type};
        ADDR_MODE:      n.rdata = {31'h0, s.abs_mode};
        ADDR_OFS_LOW:   n.rdata = s.offset[31:0];
        ADDR_OFS_HIGH:  n.rdata = s.offset[63:32];
        ADDR_SHIELD:    n.rdata = {30'h0, BATT_SHIELD};
        ADDR_MECH_POS:  n.rdata = s.mech;
        ADDR_IRQ_STAT:  n.rdata = {28'h0, s.irq_stat};
        ADDR_IRQ_MASK:  n.rdata = {28'h0, s.irq_mask};
        ADDR_STATUS:    n.rdata = {25'h0, s.enc_type == ENC_TYPE_24BIT, s.torque,
                                   s.sto_b, s.sto_a, s.fault};
        ADDR_TARGET:    n.rdata = s.target;
        ADDR_POS_ERROR: n.rdata = s.target - s.mech;
        default:        n.rdata = 32'h0;
      endcase
    end else if (s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Channels start deasserted, so torque is held off until both pins are high.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s          <= '0;
      s.enc_type <= ENC_TYPE_RESET;
      s.abs_mode <= MODE_RESET;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------
  // Safe torque off checks
  // ----------------------------------------------------------------------
  // Four low samples cover the three stages and the state register behind them.
  sto_gate_a: assert property ((!sto_chan_a)[*4] |=> !torque_enable)
    else $error("torque stayed enabled with channel a low");

  sto_chan_b_a: assert property ((!sto_chan_b)[*4] |=> !torque_enable)
    else $error("torque stayed enabled with channel b low");

  // A short glitch may leave one stage low while torque stays on, so only the
  // cycle in which torque is granted is judged, channel by channel.
  sto_both_a: assert property ($rose(torque_enable)
    |-> $past(s.sto_a || (s.sync_a[2] && s.sync_a[1]))
    && $past(s.sto_b || (s.sync_b[2] && s.sync_b[1])))
    else $error("torque enabled without both channels accepted high");

  sto_trip_a: assert property ($fell(torque_enable) |-> s.irq_stat[EV_STO_TRIP])
    else $error("torque trip not recorded in the status");

  // ----------------------------------------------------------------------
  // Encoder position and fault checks
  // ----------------------------------------------------------------------
  mode_write_a: assert property (aw_fire && s_axi_awaddr == ADDR_MODE
    && s_axi_wstrb[0] |=> s.abs_mode == $past(s_axi_wdata[0]))
    else $error("usage mode write did not take effect");

  mech_calc_a: assert property (s.abs_mode && $stable(s.raw_pos)
    && $stable(s.offset) |=> mech_position == $past(s.raw_pos[31:0] - s.offset[31:0]))
    else $error("mechanical position differs from encoder minus offset");

  // Incremental use has no turn memory, so the absolute-only faults stay quiet.
  inc_quiet_a: assert property (enc_valid && !s.abs_mode
    |=> !$rose(fault_flags[EV_OVERFLOW]) && !$rose(fault_flags[EV_BATT_FAIL]))
    else $error("absolute-only fault raised in incremental mode");

  turn_wrap_a: assert property (enc_valid && s.abs_mode && s.have_sample
    && s.prev_turns == TURN_FWD_LIMIT && enc_turns == TURN_REV_WRAP
    |=> fault_flags[EV_OVERFLOW] && s.irq_stat[EV_OVERFLOW])
    else $error("overflow past the turn limit not flagged");

  batt_first_a: assert property (enc_valid && s.abs_mode && enc_batt_first
    && !BATT_SHIELD[SHIELD_FAIL_BIT]
    |=> fault_flags[EV_BATT_FAIL] && s.offset == s.raw_pos)
    else $error("first battery power-up not flagged or offset not recorded");

  batt_irq_a: assert property (enc_valid && s.abs_mode && enc_batt_first
    && !BATT_SHIELD[SHIELD_FAIL_BIT] |=> s.irq_stat[EV_BATT_FAIL])
    else $error("first battery power-up not recorded in the status");

  batt_low_a: assert property (enc_valid && enc_batt_low
    && !BATT_SHIELD[SHIELD_LOW_BIT] |=> fault_flags[EV_BATT_LOW])
    else $error("low battery not flagged");

  // Faults leave only through a fault reset; new ones may join at any time.
  fault_hold_a: assert property (!freset_cmd
    |=> (fault_flags & $past(s.fault)) == $past(s.fault))
    else $error("latched fault dropped without fault reset");

  fault_rst_a: assert property (freset_cmd && !enc_valid |=> fault_flags == 3'h0)
    else $error("fault reset left a fault latched");

  home_abs_a: assert property (home_cmd && s.abs_mode
    |=> s.offset == $past(s.raw_pos) && s.home_base == $past(s.home_base))
    else $error("absolute homing did not move the offset only");

  // The offset clears at the first edge and the position follows one edge on.
  home_inc_a: assert property (home_cmd && !s.abs_mode && !enc_valid
    |=> s.offset == 64'h0 ##1 mech_position == 32'h0)
    else $error("incremental homing did not clear the position");

  res_low_a: assert property (enc_valid && s.enc_type != ENC_TYPE_24BIT
    |=> s.raw_pos[31:17] == $past({enc_turns[14:0]}))
    else $error("turn count misplaced for 17-bit resolution");

  res_high_a: assert property (enc_valid && s.enc_type == ENC_TYPE_24BIT
    |=> s.raw_pos[39:0] == $past({enc_turns, enc_single}))
    else $error("turn count misplaced for 24-bit resolution");

  // ----------------------------------------------------------------------
  // Register bus checks
  // ----------------------------------------------------------------------
  // The two offset halves are read as they stand; software must not expect a
  // matched pair while a new offset is being recorded.
  offset_read_a: assert property (ar_fire && s_axi_araddr == ADDR_OFS_HIGH
    |=> s_axi_rvalid && s_axi_rdata == $past(s.offset[63:32]))
    else $error("high offset word read back wrong");

  ofs_low_a: assert property (ar_fire && s_axi_araddr == ADDR_OFS_LOW
    |=> s_axi_rvalid && s_axi_rdata == $past(s.offset[31:0]))
    else $error("low offset word read back wrong");

  ro_write_a: assert property (aw_fire && !enc_valid
    && (s_axi_awaddr == ADDR_OFS_LOW || s_axi_awaddr == ADDR_OFS_HIGH)
    |=> $stable(s.offset))
    else $error("write to a read-only offset word changed it");

  bresp_map_a: assert property (aw_fire && !mapped(s_axi_awaddr)
    |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not answered with an error");

endmodule

// File: enc_model.sv
`timescale 1ns/1ps
module enc_model (
  input  wire logic        core_clk,        // System clock.
  output logic             enc_valid,       // Sample strobe.
  output logic [15:0]      enc_turns,       // Turn count.
  output logic [23:0]      enc_single,      // Single-turn position.
  output logic             enc_batt_first,  // Battery first powered.
  output logic             enc_batt_low     // Battery voltage low.
);
  // ----------------------------------------------------------------------
  // Sample delivery
  // ----------------------------------------------------------------------
  initial begin
    enc_valid      = 1'b0;
    enc_turns      = 16'h5a5a;
    enc_single     = 24'ha5a5a5;
    enc_batt_first = 1'b0;
    enc_batt_low   = 1'b0;
  end

  task automatic send(input logic [15:0] t, input logic [23:0] s, input logic f,
                      input logic l);
    @(posedge core_clk);
    enc_valid      <= 1'b1;
    enc_turns      <= t;
    enc_single     <= s;
    enc_batt_first <= f;
    enc_batt_low   <= l;
    @(posedge core_clk);
    // The lines are not held past the strobe, so stale data must never be used.
    enc_valid      <= 1'b0;
    enc_turns      <= ~t;
    enc_single     <= ~s;
    enc_batt_first <= ~f;
    enc_batt_low   <= ~l;
  endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top
  import absenc_pkg::*;
;
  logic        core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, enc_valid, enc_batt_first, enc_batt_low, sto_chan_a, sto_chan_b;
  logic        torque_enable, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, mech_position, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] enc_turns;
  logic [23:0] enc_single;
  logic [2:0]  fault_flags;
  int          err_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  absolute_encoder_position_tracker u_dut (.core_clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .enc_valid, .enc_turns, .enc_single, .enc_batt_first, .enc_batt_low,
    .sto_chan_a, .sto_chan_b, .torque_enable, .mech_position, .fault_flags, .irq);
  enc_model u_enc (.core_clk, .enc_valid, .enc_turns, .enc_single, .enc_batt_first,
    .enc_batt_low);

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Sample, then let the position pipeline settle before anything is judged.
  task automatic smp(input logic [15:0] t, input logic [23:0] s, input logic f, input logic l);
    u_enc.send(t, s, f, l);
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_regs();
    rd_reg(ADDR_MODE);     check(rd, 32'h0);
    rd_reg(ADDR_ENC_TYPE); check(rd, 32'h0);
    rd_reg(ADDR_SHIELD);   check(rd, 32'h0);
    rd_reg(ADDR_MECH_POS); check(rd, 32'h0);
    wr(ADDR_OFS_LOW, 32'h1234);
    check({30'h0, rs}, {30'h0, RESP_OKAY});
    rd_reg(ADDR_OFS_LOW);  check(rd, 32'h0);
    rd_reg(8'h30);         check({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(8'h30, 32'h0);      check({30'h0, rs}, {30'h0, RESP_SLVERR});
  endtask

  task automatic t_incremental();
    smp(16'h7fff, 24'h5, 1'b1, 1'b0);
    smp(16'h8000, 24'h5, 1'b1, 1'b0);
    check(fault_flags, 3'b000);
    wr(ADDR_CONTROL, 32'h1);
    smp(16'h8000, 24'h15, 1'b0, 1'b0);
    check(mech_position, 32'h10);
    rd_reg(ADDR_OFS_LOW); check(rd, 32'h0);
  endtask

  task automatic t_absolute();
    wr(ADDR_MODE, 32'h1);
    smp(16'h0002, 24'h100, 1'b1, 1'b0);
    check(fault_flags, 3'b010);
    smp(16'hffff, 24'h0, 1'b0, 1'b0);
    wr(ADDR_CONTROL, 32'h1);
    rd_reg(ADDR_OFS_LOW);  check(rd, 32'hfffe0000);
    rd_reg(ADDR_OFS_HIGH); check(rd, 32'hffffffff);
    smp(16'h0000, 24'h7, 1'b0, 1'b0);
    check(mech_position, 32'h20007);
    check(fault_flags, 3'b010);
    wr(ADDR_CONTROL, 32'h2);
    check(fault_flags, 3'b000);
  endtask

  task automatic t_overflow_irq();
    wr(ADDR_IRQ_MASK, 32'h1);
    smp(16'h7fff, 24'h0, 1'b0, 1'b0);
    smp(16'h8000, 24'h0, 1'b0, 1'b0);
    check(fault_flags, 3'b001);
    check(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_CONTROL, 32'h2);
    check({irq, fault_flags}, 4'h0);
    smp(16'h7fff, 24'h0, 1'b0, 1'b0);
    check(fault_flags, 3'b001);
    wr(ADDR_IRQ_MASK, 32'h0);
    check(irq, 1'b0);
    rd_reg(ADDR_IRQ_STAT); check(rd[EV_OVERFLOW], 1'b1);
    smp(16'h7fff, 24'h0, 1'b0, 1'b1);
    check(fault_flags, 3'b101);
    wr(ADDR_IRQ_STAT, 32'hf);
    wr(ADDR_CONTROL, 32'h2);
  endtask

  task automatic t_res24();
    wr(ADDR_ENC_TYPE, {16'h0, ENC_TYPE_24BIT});
    rd_reg(ADDR_STATUS); check(rd[STAT_RES24_BIT], 1'b1);
    smp(16'h0000, 24'h0, 1'b0, 1'b0);
    wr(ADDR_CONTROL, 32'h1);
    smp(16'h0001, 24'h3, 1'b0, 1'b0);
    check(mech_position, 32'h1000003);
    wr(ADDR_TARGET, 32'h1000010);
    rd_reg(ADDR_TARGET);    check(rd, 32'h1000010);
    rd_reg(ADDR_POS_ERROR); check(rd, 32'hd);
    wr(ADDR_ENC_TYPE, 32'h0);
  endtask

  task automatic t_sto();
    check(torque_enable, 1'b1);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      {sto_chan_b, sto_chan_a} <= (i == 0) ? 2'b10 : 2'b01;
      repeat (6) @(posedge core_clk);
      check(torque_enable, 1'b0);
      rd_reg(ADDR_IRQ_STAT); check(rd[EV_STO_TRIP], 1'b1);
      wr(ADDR_IRQ_STAT, 32'h8);
      {sto_chan_b, sto_chan_a} <= 2'b11;
      repeat (6) @(posedge core_clk);
      check(torque_enable, 1'b1);
    end
    sto_chan_a <= 1'b0;
    @(posedge core_clk);
    sto_chan_a <= 1'b1;
    repeat (6) begin
      @(posedge core_clk);
      check(torque_enable, 1'b1);
    end
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // The whole run needs well under two thousand cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    sys_rst       = 1'b1;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hf;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    sto_chan_a    = 1'b1;
    sto_chan_b    = 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset_regs();
    t_incremental();
    t_absolute();
    t_overflow_irq();
    t_res24();
    t_sto();
    report_and_stop();
  end
endmodule
